// ==== hdl/dtt_core.sv ====
// drift tube time digitiser core with trigger matching and axi4-lite registers
`timescale 1ns/100ps
`default_nettype none
module dtt_core (
	// clock and reset
	input  wire logic                  sys_clk_i,
	input  wire logic                  rst_i,
	// front end pins
	input  wire logic [dtt_pkg::NCH-1:0] hit_i,
	input  wire logic [dtt_pkg::NPH-1:0] phase_i,
	input  wire logic                  trg_i,
	input  wire logic                  bcr_i,
	input  wire logic                  ecr_i,
	input  wire logic                  grst_i,
	input  wire logic                  enc_i,
	// readout stream
	output logic [31:0]                ro_data_o,
	output logic                       ro_valid_o,
	input  wire logic                  ro_ready_i,
	// axi4-lite slave
	input  wire logic [7:0]            s_awaddr_i,
	input  wire logic                  s_awvalid_i,
	output logic                       s_awready_o,
	input  wire logic [31:0]           s_wdata_i,
	input  wire logic [3:0]            s_wstrb_i,
	input  wire logic                  s_wvalid_i,
	output logic                       s_wready_o,
	output logic [1:0]                 s_bresp_o,
	output logic                       s_bvalid_o,
	input  wire logic                  s_bready_i,
	input  wire logic [7:0]            s_araddr_i,
	input  wire logic                  s_arvalid_i,
	output logic                       s_arready_o,
	output logic [31:0]                s_rdata_o,
	output logic [1:0]                 s_rresp_o,
	output logic                       s_rvalid_o,
	input  wire logic                  s_rready_i
);
	localparam int N = dtt_pkg::NCH;
	typedef enum {M_IDLE, M_HEAD, M_SCAN, M_MASK, M_ERR, M_TRAIL} dtt_mst_t;

	function automatic logic [11:0] wdiff(input logic [11:0] a, input logic [11:0] b,
			input logic [11:0] r);
		if (a >= b)
			return a - b;
		return a - b + r + 12'h001;
	endfunction

	// ==========================================================
	// registers
	logic [6:0]  ctrl;
	logic [12:0] cofs;
	logic [11:0] roll, win, mwin, rofs, tofs;
	logic [3:0]  tid;
	logic        aw_rdy, ar_rdy;
	logic [31:0] rd_mux, wmask, st_word;
	dtt_pkg::dtt_edge_t em;
	dtt_pkg::dtt_full_t fm;
	assign em = dtt_pkg::dtt_edge_t'(ctrl[dtt_pkg::C_EDGE +: 2]);
	assign fm = dtt_pkg::dtt_full_t'(ctrl[dtt_pkg::C_FULL +: 2]);
	assign s_awready_o = aw_rdy;
	assign s_wready_o  = aw_rdy;
	assign s_arready_o = ar_rdy;
	assign wmask = {{8{s_wstrb_i[3]}}, {8{s_wstrb_i[2]}}, {8{s_wstrb_i[1]}}, {8{s_wstrb_i[0]}}};
	logic [31:0] wv;
	assign wv = s_wdata_i & wmask;
	always_comb begin
		unique case (s_araddr_i)
			dtt_pkg::A_CTRL: rd_mux = {25'h0, ctrl};
			dtt_pkg::A_COFS: rd_mux = {19'h0, cofs};
			dtt_pkg::A_ROLL: rd_mux = {20'h0, roll};
			dtt_pkg::A_WIN:  rd_mux = {20'h0, win};
			dtt_pkg::A_MWIN: rd_mux = {20'h0, mwin};
			dtt_pkg::A_ROFS: rd_mux = {20'h0, rofs};
			dtt_pkg::A_TOFS: rd_mux = {20'h0, tofs};
			dtt_pkg::A_ID:   rd_mux = {28'h0, tid};
			dtt_pkg::A_STAT: rd_mux = st_word;
			default:         rd_mux = 32'h0;
		endcase
	end
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			ctrl <= dtt_pkg::R_CTRL;
			cofs <= dtt_pkg::R_COFS;
			roll <= dtt_pkg::R_ROLL;
			win  <= dtt_pkg::R_WIN;
			mwin <= dtt_pkg::R_MWIN;
			rofs <= dtt_pkg::R_ROFS;
			tofs <= dtt_pkg::R_TOFS;
			tid  <= dtt_pkg::R_ID;
			aw_rdy <= 1'b0;
			ar_rdy <= 1'b0;
			s_bvalid_o <= 1'b0;
			s_bresp_o <= 2'h0;
			s_rvalid_o <= 1'b0;
			s_rresp_o <= 2'h0;
			s_rdata_o <= 32'h0;
		end else begin
			aw_rdy <= s_awvalid_i & s_wvalid_i & ~aw_rdy & ~s_bvalid_o;
			ar_rdy <= s_arvalid_i & ~ar_rdy & ~s_rvalid_o;
			if (s_bvalid_o && s_bready_i)
				s_bvalid_o <= 1'b0;
			if (s_rvalid_o && s_rready_i)
				s_rvalid_o <= 1'b0;
			if (aw_rdy) begin
				s_bvalid_o <= 1'b1;
				s_bresp_o <= 2'h0;
				unique case (s_awaddr_i)
					dtt_pkg::A_CTRL: ctrl <= (ctrl & ~wmask[6:0]) | wv[6:0];
					dtt_pkg::A_COFS: cofs <= (cofs & ~wmask[12:0]) | wv[12:0];
					dtt_pkg::A_ROLL: roll <= (roll & ~wmask[11:0]) | wv[11:0];
					dtt_pkg::A_WIN:  win  <= (win & ~wmask[11:0]) | wv[11:0];
					dtt_pkg::A_MWIN: mwin <= (mwin & ~wmask[11:0]) | wv[11:0];
					dtt_pkg::A_ROFS: rofs <= (rofs & ~wmask[11:0]) | wv[11:0];
					dtt_pkg::A_TOFS: tofs <= (tofs & ~wmask[11:0]) | wv[11:0];
					dtt_pkg::A_ID:   tid  <= (tid & ~wmask[3:0]) | wv[3:0];
					dtt_pkg::A_STAT: s_bresp_o <= 2'h0;
					default:         s_bresp_o <= 2'h2;
				endcase
			end
			if (ar_rdy) begin
				s_rvalid_o <= 1'b1;
				s_rdata_o <= rd_mux;
				s_rresp_o <= (s_araddr_i > dtt_pkg::A_STAT || s_araddr_i[1:0] != 2'h0) ? 2'h2 : 2'h0;
			end
		end
	end

	// ==========================================================
	// pin synchronisers and command decoder
	logic [N-1:0] hit_s1, hit_s2, hit_s3;
	logic [dtt_pkg::NPH-1:0] ph_s1, ph_s2;
	logic [4:0] pin_s1, pin_s2;
	logic [1:0] dcnt, dbits;
	logic dec_v;
	logic [2:0] dec_cmd;
	always_ff @(posedge sys_clk_i) begin
		hit_s1 <= hit_i;
		hit_s2 <= hit_s1;
		hit_s3 <= hit_s2;
		ph_s1 <= phase_i;
		ph_s2 <= ph_s1;
		pin_s1 <= {enc_i, grst_i, ecr_i, bcr_i, trg_i};
		pin_s2 <= pin_s1;
		if (rst_i) begin
			dcnt <= 2'h0;
			dec_v <= 1'b0;
			dbits <= 2'h0;
		end else begin
			// far end keeps commands three periods apart, so no overlap here
			dec_v <= (dcnt == 2'h1);
			dbits <= {dbits[0], pin_s2[4]};
			if (dcnt == 2'h0 && pin_s2[4])
				dcnt <= 2'h2;
			else if (dcnt != 2'h0)
				dcnt <= dcnt - 2'h1;
		end
	end
	assign dec_cmd = {1'b1, dbits};
	logic trg_c, bcr_c, ecr_c, grst_c, clr;
	assign trg_c  = pin_s2[0] | (dec_v && dec_cmd == dtt_pkg::CMD_TRG);
	assign bcr_c  = pin_s2[1] | (dec_v && dec_cmd == dtt_pkg::CMD_BCR);
	assign ecr_c  = pin_s2[2] | (dec_v && dec_cmd == dtt_pkg::CMD_ECR);
	assign grst_c = pin_s2[3] | (dec_v && dec_cmd == dtt_pkg::CMD_GRST);
	assign clr = rst_i | grst_c;

	// ==========================================================
	// coarse counter, trigger tag and event id
	logic [12:0] cc, cc_half, csel;
	logic [11:0] tcnt, evc, lost, rej;
	logic [3:0] vern;
	logic [16:0] stamp;
	always_comb begin
		vern = 4'h0;
		for (int i = 0; i < dtt_pkg::NPH; i++)
			vern = vern + {3'h0, ph_s2[i]};
	end
	// early phases mean the main counter may be mid-change
	assign csel = (vern < 4'h8) ? cc_half : cc;
	assign stamp = {csel, vern};
	assign rej = wdiff(cc[12:1], rofs, roll);
	always_ff @(posedge sys_clk_i) begin
		cc_half <= cc;
		if (clr || bcr_c)
			cc <= {cofs[12:1], 1'b0};
		else if (cc == {roll, 1'b1})
			cc <= 13'h0000;
		else
			cc <= cc + 13'h0001;
		if (clr || bcr_c)
			tcnt <= tofs;
		else if (cc[0])
			tcnt <= (tcnt == roll) ? 12'h000 : tcnt + 12'h001;
		if (clr || ecr_c)
			evc <= 12'h000;
		else if (trg_c)
			evc <= evc + 12'h001;
	end

	// ==========================================================
	// channel buffers
	dtt_pkg::dtt_meas_t chead [N];
	logic [N-1:0] ne, gnt, q;
	logic [16:0] per;
	assign per = {roll, 5'h1F} + 17'h00001;
	for (genvar g = 0; g < N; g++) begin : g_ch
		dtt_pkg::dtt_meas_t mem [dtt_pkg::CB_DEPTH];
		logic [2:0] wp, rp;
		logic loss, hl, lead, trail, push, full;
		logic [16:0] ls, dif, ws;
		dtt_pkg::dtt_meas_t e;
		assign lead  = hit_s2[g] & ~hit_s3[g];
		assign trail = ~hit_s2[g] & hit_s3[g];
		assign full  = (wp - rp) == 3'h4;
		assign dif = (stamp >= ls) ? stamp - ls : stamp - ls + per;
		assign ws = dif >> ctrl[dtt_pkg::C_WRES +: 2];
		always_comb begin
			e = '0;
			e.err = loss;
			push = 1'b0;
			unique case (em)
				dtt_pkg::E_LEAD:  push = lead;
				dtt_pkg::E_TRAIL: push = trail;
				dtt_pkg::E_BOTH:  push = lead | trail;
				dtt_pkg::E_PAIR:  push = trail & hl;
			endcase
			if (em == dtt_pkg::E_PAIR) begin
				e.pair = 1'b1;
				e.width = (|ws[16:8]) ? 8'hFF : ws[7:0];
				{e.coarse, e.fine} = ls;
			end else begin
				e.trail = trail;
				{e.coarse, e.fine} = stamp;
			end
		end
		assign chead[g] = mem[rp[1:0]];
		assign ne[g] = wp != rp;
		always_ff @(posedge sys_clk_i) begin
			if (clr) begin
				wp <= 3'h0;
				rp <= 3'h0;
				loss <= 1'b0;
				hl <= 1'b0;
				ls <= 17'h00000;
			end else begin
				if (lead) begin
					hl <= 1'b1;
					ls <= stamp;
				end else if (trail)
					hl <= 1'b0;
				if (push && full)
					loss <= 1'b1;
				else if (push) begin
					mem[wp[1:0]] <= e;
					wp <= wp + 3'h1;
					loss <= 1'b0;
				end
				if (gnt[g])
					rp <= rp + 3'h1;
			end
		end
	end

	// ==========================================================
	// encoder and first-level buffer
	dtt_pkg::dtt_l1_t l1 [dtt_pkg::L1_DEPTH];
	dtt_pkg::dtt_l1_t l1w, eb, es;
	logic [8:0] l1_wp, base, next_base, sp, next_sp, l1_cnt;
	logic l1_lost, l1_we;
	assign gnt = q & (~q + 24'h000001);
	assign l1_cnt = l1_wp - base;
	assign l1_we = |gnt;
	always_comb begin
		l1w = '0;
		for (int i = 0; i < N; i++) begin
			if (gnt[i]) begin
				l1w.m = chead[i];
				l1w.ch = 5'(i);
			end
		end
		l1w.full = l1_cnt == 9'h0FF;
		l1w.rec = l1_lost;
	end
	assign eb = l1[base[7:0]];
	assign es = l1[sp[7:0]];
	always_ff @(posedge sys_clk_i) begin
		if (clr) begin
			q <= '0;
			l1_wp <= 9'h000;
			l1_lost <= 1'b0;
		end else begin
			// queue refills only once drained, so low channels cannot starve high ones
			q <= (q == '0) ? ne : q & ~gnt;
			if (l1_we && l1_cnt == 9'h100)
				l1_lost <= 1'b1;
			else if (l1_we) begin
				l1[l1_wp[7:0]] <= l1w;
				l1_wp <= l1_wp + 9'h001;
				l1_lost <= 1'b0;
			end
		end
	end

	// ==========================================================
	// trigger fifo
	dtt_pkg::dtt_trig_t tf [dtt_pkg::TF_DEPTH];
	logic [3:0] tf_wp, tf_rp, tf_cnt;
	logic tf_pop, lost_dec, tf_full;
	assign tf_cnt = tf_wp - tf_rp;
	assign tf_full = tf_cnt == 4'h8;
	always_ff @(posedge sys_clk_i) begin
		if (clr) begin
			tf_wp <= 4'h0;
			tf_rp <= 4'h0;
			lost <= 12'h000;
		end else begin
			if (trg_c && !tf_full) begin
				tf[tf_wp[2:0]] <= '{ev: evc, tag: tcnt};
				tf_wp <= tf_wp + 4'h1;
			end
			if (tf_pop)
				tf_rp <= tf_rp + 4'h1;
			lost <= lost + {11'h0, trg_c & tf_full} - {11'h0, lost_dec};
		end
	end

	// ==========================================================
	// trigger matching
	dtt_mst_t ms, next_ms;
	dtt_pkg::dtt_trig_t cur, next_cur;
	logic lev, next_lev, nf, drop, ro_full, ro_push, hit_m;
	logic [N-1:0] mf, next_mf;
	logic [4:0] ef, next_ef;
	logic [11:0] wc, next_wc, last_ev, next_last, dm, dk;
	logic [31:0] ro_word;
	logic [6:0] ro_cnt;
	assign nf = l1_cnt >= dtt_pkg::L1_NF || tf_cnt >= dtt_pkg::TF_NF;
	assign drop = (fm == dtt_pkg::F_REJ && ro_full)
		|| (fm == dtt_pkg::F_NFREJ && (nf || ro_full));
	assign dm = wdiff(es.m.coarse, cur.tag, roll);
	assign dk = wdiff(cur.tag, es.m.coarse, roll);
	assign hit_m = dm <= win;
	always_comb begin
		next_ms = ms;
		next_cur = cur;
		next_lev = lev;
		next_mf = mf;
		next_ef = ef;
		next_last = last_ev;
		next_base = base;
		next_sp = sp;
		ro_push = 1'b0;
		ro_word = 32'h0;
		tf_pop = 1'b0;
		lost_dec = 1'b0;
		unique case (ms)
			M_IDLE: begin
				next_mf = '0;
				next_ef = {1'b0, lost != 12'h000, 3'h0};
				next_sp = base;
				if (lost != 12'h000 && (tf_cnt == 4'h0 || tf[tf_rp[2:0]].ev != last_ev + 12'h001)) begin
					lost_dec = 1'b1;
					next_cur = '{ev: last_ev + 12'h001, tag: tcnt};
					next_lev = 1'b1;
					next_ef[2] = 1'b1;
					next_ms = M_HEAD;
				end else if (tf_cnt != 4'h0) begin
					tf_pop = 1'b1;
					next_cur = tf[tf_rp[2:0]];
					next_lev = 1'b0;
					next_ms = M_HEAD;
				end else if (l1_cnt != 9'h000 && wdiff(rej, eb.m.coarse, roll) != 12'h000
						&& wdiff(rej, eb.m.coarse, roll) < 12'h800)
					next_base = base + 9'h001;
			end
			M_HEAD: if (!ro_full) begin
				ro_push = 1'b1;
				ro_word = {dtt_pkg::T_HEAD, tid, cur.ev, cur.tag};
				next_ms = lev ? M_ERR : M_SCAN;
			end
			// whole buffer is searched, so out-of-order hits are found too
			M_SCAN: if (sp == l1_wp)
				next_ms = M_MASK;
			else if (hit_m) begin
				if (drop)
					next_ef[1] = 1'b1;
				else if (!ro_full) begin
					ro_push = 1'b1;
					ro_word = es.m.pair
						? {dtt_pkg::T_COMB, tid, es.ch, es.m.width, es.m.coarse[5:0], es.m.fine}
						: {dtt_pkg::T_SGL, tid, es.ch, es.m.trail, es.m.err, es.m.coarse, es.m.fine};
				end
				if (drop || !ro_full) begin
					next_sp = sp + 9'h001;
					next_ef[0] = ef[0] | es.full | es.rec;
					next_ef[4] = ef[4] | es.m.err;
				end
			end else begin
				if (ctrl[dtt_pkg::C_MSKE] && dk != 12'h000 && dk <= mwin)
					next_mf[es.ch] = 1'b1;
				next_sp = sp + 9'h001;
			end
			M_MASK: if (mf == '0)
				next_ms = M_ERR;
			else if (drop || !ro_full) begin
				ro_push = !drop;
				next_ef[1] = ef[1] | drop;
				ro_word = {dtt_pkg::T_MASK, tid, mf};
				next_ms = M_ERR;
			end
			M_ERR: if (ef == 5'h00)
				next_ms = M_TRAIL;
			else if (!ro_full) begin
				ro_push = 1'b1;
				ro_word = {dtt_pkg::T_ERR, tid, 19'h00000, ef};
				next_ms = M_TRAIL;
			end
			M_TRAIL: if (!ro_full) begin
				ro_push = 1'b1;
				ro_word = {dtt_pkg::T_TRAIL, tid, cur.ev, wc + 12'h001};
				next_last = cur.ev;
				next_ms = M_IDLE;
			end
		endcase
		next_wc = (ms == M_IDLE) ? 12'h000 : wc + {11'h0, ro_push};
		if (ecr_c)
			next_last = 12'hFFF;
	end
	always_ff @(posedge sys_clk_i) begin
		if (clr) begin
			ms <= M_IDLE;
			cur <= '0;
			lev <= 1'b0;
			mf <= '0;
			ef <= 5'h00;
			wc <= 12'h000;
			last_ev <= 12'hFFF;
			base <= 9'h000;
			sp <= 9'h000;
		end else begin
			ms <= next_ms;
			cur <= next_cur;
			lev <= next_lev;
			mf <= next_mf;
			ef <= next_ef;
			wc <= next_wc;
			last_ev <= next_last;
			base <= next_base;
			sp <= next_sp;
		end
	end

	// ==========================================================
	// readout fifo
	logic [31:0] ro [dtt_pkg::RO_DEPTH];
	logic [6:0] ro_wp, ro_rp;
	assign ro_cnt = ro_wp - ro_rp;
	assign ro_full = ro_cnt == 7'h40;
	assign st_word = {4'h0, ro_cnt, l1_cnt, lost};
	always_ff @(posedge sys_clk_i) begin
		if (clr) begin
			ro_wp <= 7'h00;
			ro_rp <= 7'h00;
			ro_valid_o <= 1'b0;
			ro_data_o <= 32'h0;
		end else begin
			if (ro_push) begin
				ro[ro_wp[5:0]] <= ro_word;
				ro_wp <= ro_wp + 7'h01;
			end
			if ((!ro_valid_o || ro_ready_i) && ro_cnt != 7'h00) begin
				ro_data_o <= ro[ro_rp[5:0]];
				ro_valid_o <= 1'b1;
				ro_rp <= ro_rp + 7'h01;
			end else if (ro_ready_i)
				ro_valid_o <= 1'b0;
		end
	end

	// ==========================================================
	// assertions
	// word count kept apart from the matcher, restarted by every header word
	logic [11:0] chk_wc;
	always_ff @(posedge sys_clk_i) begin
		if (clr)
			chk_wc <= 12'h000;
		else if (ro_push)
			chk_wc <= (ro_word[31:28] == dtt_pkg::T_HEAD) ? 12'h001 : chk_wc + 12'h001;
	end
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);
	a_dec_latency: assert property ((dcnt == 2'h0 && pin_s2[4]) |-> ##3 dec_v)
		else $error("decoder did not answer three cycles after start bit");
	a_queue_frozen: assert property ((q != '0 && !clr) |=> (q & ~$past(q)) == '0)
		else $error("channel admitted to busy queue");
	a_coarse_load: assert property ((grst_c && !rst_i) |=> cc == {$past(cofs[12:1]), 1'b0})
		else $error("coarse counter not loaded with even offset");
	a_l1_bound: assert property (l1_cnt <= 9'h100)
		else $error("first-level buffer overfilled");
	a_ro_noovf: assert property (ro_push |-> !ro_full)
		else $error("readout fifo written while full");
	a_head_first: assert property ((ms == M_HEAD && !ro_full) |=> $past(ro_word[31:28]) == dtt_pkg::T_HEAD && ms != M_HEAD)
		else $error("header not written first");
	a_trail_count: assert property ((ms == M_TRAIL && ro_push) |-> ro_word[11:0] == chk_wc + 12'h001)
		else $error("trailer word count wrong");
	a_lost_count: assert property ((trg_c && tf_full && !lost_dec && !clr) |=> lost == $past(lost) + 12'h001)
		else $error("lost trigger not counted");
	a_mask_clear: assert property ((ms == M_IDLE && next_ms == M_HEAD && !clr) |=> mf == '0)
		else $error("mask flags carried over");
	a_drop_flag: assert property ((ms == M_SCAN && sp != l1_wp && hit_m && drop && !clr) |=> ef[1])
		else $error("dropped data not flagged");
	c_lost_event: cover property (lost_dec);
	c_mask_word: cover property (ms == M_MASK && ro_push);
	c_drop: cover property (ms == M_SCAN && hit_m && drop);
	c_l1_full: cover property (l1_we && l1_cnt == 9'h0FF);
endmodule
`default_nettype wire

// ==== hdl/dtt_pkg.sv ====
// shared constants and types for the drift tube time digitiser core
package dtt_pkg;
	localparam int NCH      = 24;
	localparam int CB_DEPTH = 4;
	localparam int L1_DEPTH = 256;
	localparam int TF_DEPTH = 8;
	localparam int RO_DEPTH = 64;
	localparam int NPH      = 16;
	// register byte offsets
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_COFS = 8'h04;
	localparam logic [7:0] A_ROLL = 8'h08;
	localparam logic [7:0] A_WIN  = 8'h0C;
	localparam logic [7:0] A_MWIN = 8'h10;
	localparam logic [7:0] A_ROFS = 8'h14;
	localparam logic [7:0] A_TOFS = 8'h18;
	localparam logic [7:0] A_ID   = 8'h1C;
	localparam logic [7:0] A_STAT = 8'h20;
	// ctrl fields: [1:0] edge mode, [3:2] full mode, [4] mask enable, [6:5] width shift
	localparam int C_EDGE = 0;
	localparam int C_FULL = 2;
	localparam int C_MSKE = 4;
	localparam int C_WRES = 5;
	// reset values
	localparam logic [6:0]  R_CTRL = 7'h02;
	localparam logic [12:0] R_COFS = 13'h0000;
	localparam logic [11:0] R_ROLL = 12'hFFF;
	localparam logic [11:0] R_WIN  = 12'h020;
	localparam logic [11:0] R_MWIN = 12'h008;
	localparam logic [11:0] R_ROFS = 12'h100;
	localparam logic [11:0] R_TOFS = 12'h000;
	localparam logic [3:0]  R_ID   = 4'h0; // arbitrary neutral value
	// encoded commands
	localparam logic [2:0] CMD_TRG  = 3'h4;
	localparam logic [2:0] CMD_BCR  = 3'h6;
	localparam logic [2:0] CMD_GRST = 3'h5;
	localparam logic [2:0] CMD_ECR  = 3'h7;
	// word types
	localparam logic [3:0] T_HEAD  = 4'hA;
	localparam logic [3:0] T_TRAIL = 4'hC;
	localparam logic [3:0] T_MASK  = 4'h2;
	localparam logic [3:0] T_SGL   = 4'h3;
	localparam logic [3:0] T_COMB  = 4'h4;
	localparam logic [3:0] T_ERR   = 4'h6;
	// nearly full thresholds
	localparam logic [8:0] L1_NF = 9'h0F0;
	localparam logic [3:0] TF_NF = 4'h7;
	typedef enum logic [1:0] {E_LEAD, E_TRAIL, E_BOTH, E_PAIR} dtt_edge_t;
	typedef enum logic [1:0] {F_BACKP, F_NFREJ, F_REJ, F_RSVD} dtt_full_t;
	typedef struct packed {
		logic        pair;
		logic        trail;
		logic        err;
		logic [7:0]  width;
		logic [11:0] coarse;
		logic [4:0]  fine;
	} dtt_meas_t;
	typedef struct packed {
		dtt_meas_t  m;
		logic [4:0] ch;
		logic       full;
		logic       rec;
	} dtt_l1_t;
	typedef struct packed {
		logic [11:0] ev;
		logic [11:0] tag;
	} dtt_trig_t;
endpackage

// ==== sim/dtt_partner.sv ====
// far side model: encoded command source and readout sink
`timescale 1ns/100ps
`default_nettype none
module dtt_partner (
	// clock
	input  wire logic sys_clk_i,
	// encoded command line
	output logic      enc_o,
	// readout sink
	input  wire logic ro_valid_i,
	output logic      ro_ready_o
);
	logic [1:0] phase_cnt;
	initial begin
		enc_o = 1'b0;
		ro_ready_o = 1'b0;
		phase_cnt = 2'h0;
	end
	//==========
	// sink stalls one cycle in four so held words get exercised
	always @(posedge sys_clk_i) begin
		phase_cnt <= phase_cnt + 2'h1;
		ro_ready_o <= (phase_cnt != 2'h3);
	end
	//==========
	// start bit, two code bits, then idle to keep commands spaced
	task automatic send_cmd(input logic [1:0] code);
		@(posedge sys_clk_i);
		enc_o <= 1'b1;
		@(posedge sys_clk_i);
		enc_o <= code[1];
		@(posedge sys_clk_i);
		enc_o <= code[0];
		@(posedge sys_clk_i);
		enc_o <= 1'b0;
		repeat (3) @(posedge sys_clk_i);
	endtask
endmodule
`default_nettype wire

// ==== sim/tb_top.sv ====
// self-checking bench for the digitiser core
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	//==========
	// signals
	logic        sys_clk = 1'b0;
	logic        rst     = 1'b1;
	logic [23:0] hit     = 24'h0;
	logic [15:0] phase   = 16'h0;
	logic        trg     = 1'b0;
	logic        grst    = 1'b0;
	logic        enc, ro_valid, ro_ready;
	logic [31:0] ro_data, rdata;
	logic [7:0]  awaddr  = 8'h0;
	logic [7:0]  araddr  = 8'h0;
	logic [31:0] wdata   = 32'h0;
	logic        awvalid = 1'b0;
	logic        wvalid  = 1'b0;
	logic        bready  = 1'b0;
	logic        arvalid = 1'b0;
	logic        rready  = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp;
	logic [31:0] seed    = 32'h68E0;
	logic [63:0] expq[$];
	logic [63:0] e;
	logic [31:0] r;
	logic [4:0]  a, b;
	int          errors = 0;
	int          tests_run = 0;
	int          cyc = 0;
	always #5 sys_clk = ~sys_clk;
	dtt_core u_dtt_core (
		.sys_clk_i(sys_clk), .rst_i(rst), .hit_i(hit), .phase_i(phase),
		.trg_i(trg), .bcr_i(1'b0), .ecr_i(1'b0), .grst_i(grst), .enc_i(enc),
		.ro_data_o(ro_data), .ro_valid_o(ro_valid), .ro_ready_i(ro_ready),
		.s_awaddr_i(awaddr), .s_awvalid_i(awvalid), .s_awready_o(awready),
		.s_wdata_i(wdata), .s_wstrb_i(4'hF), .s_wvalid_i(wvalid), .s_wready_o(wready),
		.s_bresp_o(bresp), .s_bvalid_o(bvalid), .s_bready_i(bready),
		.s_araddr_i(araddr), .s_arvalid_i(arvalid), .s_arready_o(arready),
		.s_rdata_o(rdata), .s_rresp_o(rresp), .s_rvalid_o(rvalid), .s_rready_i(rready));
	dtt_partner u_dtt_partner (.sys_clk_i(sys_clk), .enc_o(enc),
		.ro_valid_i(ro_valid), .ro_ready_o(ro_ready));
	//==========
	// helpers
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		tests_run++;
		if (seen !== want) begin
			errors++;
			$display("CHECK FAILED t=%0t seen %h want %h", $time, seen, want);
		end
	endtask
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic note(input logic [31:0] m, input logic [31:0] v);
		expq.push_back({m, v});
	endtask
	task automatic hdr(input logic [11:0] ev);
		note(32'hFFFF_F000, {dtt_pkg::T_HEAD, dtt_pkg::R_ID, ev, 12'h000});
	endtask
	task automatic trl(input logic [11:0] ev, input logic [11:0] n);
		note(32'hFFFF_FFFF, {dtt_pkg::T_TRAIL, dtt_pkg::R_ID, ev, n});
	endtask
	task automatic sgl(input logic [4:0] c, input logic t);
		note(32'hFFFE_0000, {dtt_pkg::T_SGL, dtt_pkg::R_ID, c, t, 18'h0});
	endtask
	task automatic axi_wr(input logic [7:0] ad, input logic [31:0] d, input logic [1:0] rs);
		// idle edge first, so the ready of the last call is not raised again at once
		@(posedge sys_clk);
		awaddr <= ad;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		fork
			begin
				do @(posedge sys_clk); while (awready !== 1'b1);
				awvalid <= 1'b0;
			end
			begin
				do @(posedge sys_clk); while (wready !== 1'b1);
				wvalid <= 1'b0;
			end
		join
		do @(posedge sys_clk); while (bvalid !== 1'b1);
		bready <= 1'b0;
		check({30'h0, bresp}, {30'h0, rs});
	endtask
	task automatic axi_rd(input logic [7:0] ad, input logic [31:0] d, input logic [1:0] rs);
		@(posedge sys_clk);
		araddr <= ad;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge sys_clk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge sys_clk); while (rvalid !== 1'b1);
		rready <= 1'b0;
		check(rdata, d);
		check({30'h0, rresp}, {30'h0, rs});
	endtask
	task automatic pulse(input logic [23:0] m, input int len);
		hit <= m;
		repeat (len) @(posedge sys_clk);
		hit <= 24'h0;
		repeat (20) @(posedge sys_clk);
	endtask
	task automatic fire();
		trg <= 1'b1;
		@(posedge sys_clk);
		trg <= 1'b0;
		do @(posedge sys_clk); while (expq.size() != 0);
		repeat (30) @(posedge sys_clk);
	endtask
	//==========
	// monitor and stimulus
	always @(posedge sys_clk) begin
		phase <= 16'(rnd());
		cyc++;
		if (cyc == 20000) begin
			errors++;
			report_and_stop();
		end
		if (ro_valid === 1'b1 && ro_ready === 1'b1) begin
			e = (expq.size() != 0) ? expq.pop_front() : {32'hFFFF_FFFF, 32'hDEAD_BEEF};
			check(ro_data & e[63:32], e[31:0]);
		end
	end
	initial begin
		repeat (6) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		check({31'h0, ro_valid}, 32'h0);
		axi_rd(dtt_pkg::A_CTRL, 32'(dtt_pkg::R_CTRL), 2'h0);
		axi_rd(dtt_pkg::A_COFS, 32'(dtt_pkg::R_COFS), 2'h0);
		axi_rd(dtt_pkg::A_ROLL, 32'(dtt_pkg::R_ROLL), 2'h0);
		axi_rd(dtt_pkg::A_ROFS, 32'(dtt_pkg::R_ROFS), 2'h0);
		axi_rd(dtt_pkg::A_MWIN, 32'(dtt_pkg::R_MWIN), 2'h0);
		axi_rd(dtt_pkg::A_WIN, 32'(dtt_pkg::R_WIN), 2'h0);
		axi_wr(dtt_pkg::A_WIN, 32'hFFF, 2'h0);
		axi_rd(dtt_pkg::A_WIN, 32'hFFF, 2'h0);
		axi_wr(8'h24, 32'h5, 2'h2);
		axi_rd(8'h24, 32'h0, 2'h2);
		// leading edges only, two channels hit together
		axi_wr(dtt_pkg::A_CTRL, 32'h0, 2'h0);
		r = rnd();
		a = 5'(r % 12);
		b = 5'(12 + (r >> 8) % 12);
		hdr(12'h0);
		sgl(a, 1'b0);
		sgl(b, 1'b0);
		trl(12'h0, 12'h4);
		pulse((24'h1 << a) | (24'h1 << b), 4);
		fire();
		// both edges, encoded bunch reset and global reset, encoded trigger
		axi_wr(dtt_pkg::A_CTRL, 32'h2, 2'h0);
		u_dtt_partner.send_cmd(2'(dtt_pkg::CMD_BCR));
		u_dtt_partner.send_cmd(2'(dtt_pkg::CMD_GRST));
		a = 5'(rnd() % 24);
		hdr(12'h0);
		sgl(a, 1'b0);
		sgl(a, 1'b1);
		trl(12'h0, 12'h4);
		// the direct trigger of fire makes event 1 over the same hits
		hdr(12'h1);
		sgl(a, 1'b0);
		sgl(a, 1'b1);
		trl(12'h1, 12'h4);
		pulse(24'h1 << a, 5);
		u_dtt_partner.send_cmd(2'(dtt_pkg::CMD_TRG));
		fire();
		// paired edges, direct global reset then encoded one
		axi_wr(dtt_pkg::A_CTRL, 32'h3, 2'h0);
		grst <= 1'b1;
		@(posedge sys_clk);
		grst <= 1'b0;
		u_dtt_partner.send_cmd(2'(dtt_pkg::CMD_GRST));
		hdr(12'h0);
		note(32'hFFF8_0000, {dtt_pkg::T_COMB, dtt_pkg::R_ID, a, 19'h0});
		trl(12'h0, 12'h3);
		pulse(24'h1 << a, 8);
		fire();
		hdr(12'h1);
		note(32'hFFF8_0000, {dtt_pkg::T_COMB, dtt_pkg::R_ID, a, 19'h0});
		trl(12'h1, 12'h3);
		fire();
		u_dtt_partner.send_cmd(2'(dtt_pkg::CMD_ECR));
		repeat (800) @(posedge sys_clk);
		// old hit rejected while no trigger waits
		hdr(12'h0);
		trl(12'h0, 12'h2);
		fire();
		report_and_stop();
	end
endmodule
`default_nettype wire
